// ==== logic/lsrp_pkg.sv ====
package lsrp_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [4:0] ControlAddr    = 5'h00;
   localparam logic [4:0] TimingAddr     = 5'h01;
   localparam logic [4:0] IntCtrlAddr    = 5'h02;
   localparam logic [4:0] LowThLoAddr    = 5'h03;
   localparam logic [4:0] AnalogAddr     = 5'h07;
   localparam logic [4:0] PartRevAddr    = 5'h12;
   localparam logic [4:0] Ch0LoAddr      = 5'h14;
   localparam logic [4:0] Ch0HiAddr      = 5'h15;
   localparam logic [4:0] Ch1LoAddr      = 5'h16;
   localparam logic [4:0] Ch1HiAddr      = 5'h17;
   localparam logic [4:0] ManLoAddr      = 5'h18;
   localparam logic [4:0] ManHiAddr      = 5'h19;
   localparam logic [4:0] VariantAddr    = 5'h1e;

   // ------------------------------------------------------------
   // command byte fields
   // ------------------------------------------------------------
   localparam int         CmdBit         = 7;
   localparam logic [1:0] XferRepeat     = 2'h0;
   localparam logic [1:0] XferIncr       = 2'h1;
   localparam logic [1:0] XferSpecial    = 2'h3;
   localparam logic [4:0] SfClearInt     = 5'h01;
   localparam logic [4:0] SfStopManual   = 5'h02;
   localparam logic [4:0] SfStartManual  = 5'h03;
   localparam logic [7:0] CommandReset   = 8'h00;
   localparam logic [7:0] TimingReset    = 8'h00;
   localparam logic [7:0] TimingManual   = 8'h00;

   // control register bits
   localparam int         PowerBit       = 0;
   localparam int         AdcEnBit       = 1;
   localparam int         ValidBit       = 4;
   localparam int         IntrBit        = 5;

   // ------------------------------------------------------------
   // target addresses picked by the select pin
   // ------------------------------------------------------------
   localparam logic [6:0] AddrGnd        = 7'h29;
   localparam logic [6:0] AddrFloat      = 7'h39;
   localparam logic [6:0] AddrVdd        = 7'h49;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int         ClkHz          = 100_000_000;
   localparam int         StepUs         = 2700;
   localparam int         StepCycles     = StepUs * (ClkHz / 1_000_000);

   typedef enum logic [1:0] {
      SelGnd,
      SelFloat,
      SelVdd
   } addr_sel_t;

   // one finished conversion from the converters
   typedef struct packed {
      logic [15:0] chan0;
      logic [15:0] chan1;
   } conv_result_t;

endpackage

// ==== logic/light_sensor_serial_register_port.sv ====
`timescale 1ns/1ps
// What this block does
// - integrate both channels, latch each result
// - double buffer results, no capture during read bytes and acks
// - restart integration automatically in timed mode, manual mode waits for start
// - address chosen by select pin level
// - seven bit addressing, standard and fast
// - first written byte with msb set is the command
// - combined: command, repeated start, then reads
// - read without command uses stored address
// - msb clear: data written at stored address
// - bits six five select transfer style
// - low five bits: address or function
// - special code one clears interrupt
// - manual start three, stop two, timing zero
// - manual length readable at 18h, 19h
// - command register resets to zero
// - block transfer runs until stop
// - channel results readable at 14h-17h
// - control: power, enable, valid, interrupt flags
// - timing is negated step count, zero manual
module light_sensor_serial_register_port
   import lsrp_pkg::*;
#(
   parameter int STEP_CYCLES = lsrp_pkg::StepCycles
) (
   input  wire logic                      clk,
   input  wire logic                      rst_b,
   input  wire logic                      clkEn,
   input  wire logic                      sclIn,
   input  wire logic                      sdaIn,
   output logic                           sdaOe,
   output logic                           sdaOut,
   input  wire lsrp_pkg::addr_sel_t       addrSel,
   input  wire logic                      convDone,
   input  wire lsrp_pkg::conv_result_t    convResult,
   input  wire logic                      intEvent,
   output logic                           powerOn,
   output logic                           adcEnable,
   output logic                           integrating,
   output logic                           intOut
);
   import lsrp_pkg::*;

   // ------------------------------------------------------------
   // reset and input synchronisers
   // ------------------------------------------------------------
   logic       rstMeta_r, rstSync_r;
   logic [1:0] sclSync_r, sdaSync_r;
   logic       sclPrev_r, sdaPrev_r;
   addr_sel_t  selMeta_r, selSync_r;

   // reset release through two flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   // bus pins pass two flops before use
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         sclSync_r <= 2'h3;
         sdaSync_r <= 2'h3;
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
         selMeta_r <= SelGnd;
         selSync_r <= SelGnd;
      end else if (clkEn) begin
         sclSync_r <= {sclSync_r[0], sclIn};
         sdaSync_r <= {sdaSync_r[0], sdaIn};
         sclPrev_r <= sclSync_r[1];
         sdaPrev_r <= sdaSync_r[1];
         selMeta_r <= addrSel;
         selSync_r <= selMeta_r;
      end
   end

   logic scl, sda, sclRise, sclFall, startCond, stopCond;
   assign scl       = sclSync_r[1];
   assign sda       = sdaSync_r[1];
   assign sclRise   = scl & ~sclPrev_r;
   assign sclFall   = ~scl & sclPrev_r;
   assign startCond = scl & sclPrev_r & sdaPrev_r & ~sda;
   assign stopCond  = scl & sclPrev_r & ~sdaPrev_r & sda;

   // ------------------------------------------------------------
   // address selection
   // ------------------------------------------------------------
   logic [6:0] myAddr;
   always_comb begin
      case (selSync_r)
         SelGnd:   myAddr = AddrGnd;
         SelVdd:   myAddr = AddrVdd;
         default:  myAddr = AddrFloat;
      endcase
   end

   // ------------------------------------------------------------
   // serial byte engine
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      Idle,
      AddrByte,
      AddrAck,
      WrByte,
      WrAck,
      RdByte,
      RdAck
   } bus_state_t;

   bus_state_t  state_r;
   logic [7:0]  shift_r;
   logic [2:0]  bitCnt_r;
   logic        firstByte_r;
   logic        byteDone_r;
   logic        wrStrobe;
   logic        rdLoad;
   logic [7:0]  rdData;
   logic [7:0]  command_r;
   logic        cmdStrobe;

   // a written byte is the command only when first and msb set
   assign cmdStrobe = wrStrobe & firstByte_r & shift_r[CmdBit];

   // byte engine: seven bit address plus direction, ack, data
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         state_r     <= Idle;
         shift_r     <= 8'h00;
         bitCnt_r    <= 3'h0;
         firstByte_r <= 1'b0;
         byteDone_r  <= 1'b0;
         sdaOe       <= 1'b0;
         sdaOut      <= 1'b0;
      end else if (clkEn) begin
         if (startCond) begin
            state_r  <= AddrByte;
            bitCnt_r <= 3'h0;
            byteDone_r <= 1'b0;
            sdaOe    <= 1'b0;
         end else if (stopCond) begin
            state_r <= Idle;
            sdaOe   <= 1'b0;
         end else begin
            case (state_r)
               AddrByte, WrByte: begin
                  if (sclRise) begin
                     shift_r  <= {shift_r[6:0], sda};
                     bitCnt_r <= bitCnt_r + 3'h1;
                     byteDone_r <= (bitCnt_r == 3'h7);
                  end
                  if (sclFall && byteDone_r && state_r == AddrByte &&
                      shift_r[7:1] == myAddr) begin
                     sdaOe   <= 1'b1;
                     state_r <= AddrAck;
                  end else if (sclFall && byteDone_r && state_r == AddrByte) begin
                     state_r <= Idle;
                  end else if (sclFall && byteDone_r) begin
                     sdaOe   <= 1'b1;
                     state_r <= WrAck;
                  end
               end
               AddrAck: begin
                  if (sclFall) begin
                     firstByte_r <= ~shift_r[0];
                     shift_r     <= shift_r[0] ? rdData : 8'h00;
                     sdaOe       <= shift_r[0] & ~rdData[7];
                     state_r     <= shift_r[0] ? RdByte : WrByte;
                  end
               end
               WrAck: begin
                  if (sclFall) begin
                     firstByte_r <= 1'b0;
                     shift_r     <= 8'h00;
                     sdaOe       <= 1'b0;
                     state_r     <= WrByte;
                  end
               end
               RdByte: begin
                  if (sclFall) begin
                     bitCnt_r <= bitCnt_r + 3'h1;
                     shift_r  <= {shift_r[6:0], 1'b0};
                     sdaOe    <= (bitCnt_r != 3'h7) & ~shift_r[6];
                     if (bitCnt_r == 3'h7) state_r <= RdAck;
                  end
               end
               RdAck: begin
                  if (sclRise && sda) begin
                     state_r <= Idle; // master not acknowledging ends read
                  end else if (sclFall) begin
                     shift_r <= rdData;
                     sdaOe   <= ~rdData[7];
                     state_r <= RdByte;
                  end
               end
               default: state_r <= Idle;
            endcase
         end
      end
   end

   // the write strobe and the read load strobe
   assign wrStrobe = clkEn & (state_r == WrAck) & sclFall;
   assign rdLoad   = clkEn & sclFall &
                     ((state_r == AddrAck & shift_r[0]) | state_r == RdAck);

   // ------------------------------------------------------------
   // command register and address pointer
   // ------------------------------------------------------------
   logic [4:0] regAddr_r;
   logic       sfPending_r;

   // command latch and pointer stepping
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         command_r   <= CommandReset;
         regAddr_r   <= 5'h00;
         sfPending_r <= 1'b0;
      end else if (clkEn) begin
         if (cmdStrobe) begin
            command_r   <= shift_r;
            sfPending_r <= (shift_r[6:5] == XferSpecial);
            if (shift_r[6:5] != XferSpecial)
               regAddr_r <= shift_r[4:0];
         end else if (wrStrobe || rdLoad) begin
            sfPending_r <= 1'b0;
            if (command_r[6:5] == XferIncr)
               regAddr_r <= regAddr_r + 5'h01;
         end else if (stopCond) begin
            sfPending_r <= 1'b0;
         end
      end
   end

   // data byte goes to stored pointer, also a first byte without msb
   logic dataWr;
   assign dataWr = wrStrobe & ~cmdStrobe &
                   (command_r[6:5] != XferSpecial);
   // special function acts on stop of a send byte transaction
   logic sfFire;
   assign sfFire = clkEn & stopCond & sfPending_r;

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [7:0] timing_r, intCtrl_r, analog_r, variant_r;
   logic [7:0] thresh_r [4];
   logic       intFlag_r;

   // host writable registers
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         powerOn   <= 1'b0;
         adcEnable <= 1'b0;
         timing_r  <= TimingReset;
         intCtrl_r <= 8'h00;
         analog_r  <= 8'h00;
         variant_r <= 8'h00;
         for (int i = 0; i < 4; i++) thresh_r[i] <= 8'h00;
      end else if (clkEn && dataWr) begin
         if (regAddr_r == ControlAddr) begin
            powerOn   <= shift_r[PowerBit];
            adcEnable <= shift_r[AdcEnBit];
         end else if (regAddr_r == TimingAddr) begin
            timing_r <= shift_r;
         end else if (regAddr_r == IntCtrlAddr) begin
            intCtrl_r <= shift_r;
         end else if (regAddr_r >= LowThLoAddr && regAddr_r < AnalogAddr) begin
            thresh_r[2'(regAddr_r - LowThLoAddr)] <= shift_r;
         end else if (regAddr_r == AnalogAddr) begin
            analog_r <= shift_r;
         end else if (regAddr_r == VariantAddr) begin
            variant_r <= shift_r;
         end
      end
   end

   // interrupt flag: event set wins over clear
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         intFlag_r <= 1'b0;
         intOut    <= 1'b0;
      end else if (clkEn) begin
         if (intEvent) intFlag_r <= 1'b1;
         else if (sfFire && command_r[4:0] == SfClearInt) intFlag_r <= 1'b0;
         intOut <= intFlag_r;
      end
   end

   // ------------------------------------------------------------
   // conversion results, manual timer, free running cycle
   // ------------------------------------------------------------
   conv_result_t result_r;
   logic         valid_r;
   logic [15:0]  manLen_r, manCnt_r;
   logic [31:0]  stepDiv_r;
   logic         manual;
   assign manual = (timing_r == TimingManual);

   // double buffered capture, never while in a read byte or its ack
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         result_r <= '0;
         valid_r  <= 1'b0;
      end else if (clkEn) begin
         if (convDone && !(state_r == RdByte || state_r == RdAck)) begin
            result_r <= convResult;
            valid_r  <= 1'b1;
         end else if (!adcEnable) begin
            valid_r <= 1'b0;
         end
      end
   end

   // integration running: timed mode restarts itself, manual by command
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         integrating <= 1'b0;
         manCnt_r    <= 16'h0000;
         manLen_r    <= 16'h0000;
         stepDiv_r   <= 32'h0;
      end else if (clkEn) begin
         if (!powerOn || !adcEnable) begin
            integrating <= 1'b0;
         end else if (dataWr && regAddr_r == TimingAddr) begin
            integrating <= 1'b0;
         end else if (!manual) begin
            integrating <= 1'b1;
         end else if (sfFire && command_r[4:0] == SfStartManual) begin
            integrating <= 1'b1;
            manCnt_r    <= 16'h0000;
            stepDiv_r   <= 32'h0;
         end else if (sfFire && command_r[4:0] == SfStopManual) begin
            integrating <= 1'b0;
            manLen_r    <= manCnt_r;
         end else if (integrating) begin
            if (stepDiv_r == 32'(STEP_CYCLES - 1)) begin
               stepDiv_r <= 32'h0;
               manCnt_r  <= manCnt_r + 16'h0001;
            end else begin
               stepDiv_r <= stepDiv_r + 32'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always_comb begin
      if (regAddr_r == ControlAddr) begin
         rdData = 8'h00;
         rdData[PowerBit] = powerOn;
         rdData[AdcEnBit] = adcEnable;
         rdData[ValidBit] = valid_r;
         rdData[IntrBit]  = intFlag_r;
      end else if (regAddr_r == TimingAddr) begin
         rdData = timing_r;
      end else if (regAddr_r == IntCtrlAddr) begin
         rdData = intCtrl_r;
      end else if (regAddr_r >= LowThLoAddr && regAddr_r < AnalogAddr) begin
         rdData = thresh_r[2'(regAddr_r - LowThLoAddr)];
      end else if (regAddr_r == AnalogAddr) begin
         rdData = analog_r;
      end else if (regAddr_r == PartRevAddr) begin
         rdData = 8'h5a; // arbitrary identity value
      end else if (regAddr_r == Ch0LoAddr) begin
         rdData = result_r.chan0[7:0];
      end else if (regAddr_r == Ch0HiAddr) begin
         rdData = result_r.chan0[15:8];
      end else if (regAddr_r == Ch1LoAddr) begin
         rdData = result_r.chan1[7:0];
      end else if (regAddr_r == Ch1HiAddr) begin
         rdData = result_r.chan1[15:8];
      end else if (regAddr_r == ManLoAddr) begin
         rdData = manLen_r[7:0];
      end else if (regAddr_r == ManHiAddr) begin
         rdData = manLen_r[15:8];
      end else if (regAddr_r == VariantAddr) begin
         rdData = variant_r;
      end else begin
         rdData = 8'h00;
      end
   end

endmodule

// ==== sim/lsrp_properties.sv ====
`timescale 1ns/1ps
// --------------------------------------------------------------
// port checker for the serial register port
// --------------------------------------------------------------
module lsrp_properties
   import lsrp_pkg::*;
#(
   parameter int STEP_CYCLES = 10
) (
   input wire logic                   clk,
   input wire logic                   rst_b,
   input wire logic                   clkEn,
   input wire logic                   sclIn,
   input wire logic                   sdaIn,
   input wire logic                   sdaOe,
   input wire logic                   sdaOut,
   input wire lsrp_pkg::addr_sel_t    addrSel,
   input wire logic                   convDone,
   input wire lsrp_pkg::conv_result_t convResult,
   input wire logic                   intEvent,
   input wire logic                   powerOn,
   input wire logic                   adcEnable,
   input wire logic                   integrating,
   input wire logic                   intOut
);
   logic [3:0] evHist_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // recent interrupt events, newest in bit 0
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         evHist_r <= 4'h0;
      end else begin
         evHist_r <= {evHist_r[2:0], intEvent};
      end
   end

   sda_drive_low_a: assert property (sdaOut == 1'b0)
      else $error("data line driven to a high level");
   reset_outputs_a: assert property ($rose(rst_b) |->
      !sdaOe && !powerOn && !adcEnable && !intOut && !integrating)
      else $error("outputs not cleared by reset");
   freeze_hold_a: assert property (!clkEn |=>
      $stable({powerOn, adcEnable, integrating, intOut, sdaOe}))
      else $error("state moved while frozen");
   ack_edge_a: assert property ($changed(sdaOe) |-> !sclIn && !$past(sclIn))
      else $error("data line changed while clock high");
   ctrl_write_a: assert property ($changed(powerOn) || $changed(adcEnable) |->
      !sclIn && !$past(sclIn))
      else $error("control changed outside data ack");
   int_set_a: assert property (intEvent && clkEn |-> ##[1:4] intOut)
      else $error("interrupt event not flagged");
   int_cause_a: assert property ($rose(intOut) |-> evHist_r != 4'h0)
      else $error("interrupt raised without event");
   int_clear_a: assert property ($fell(intOut) |-> sclIn && sdaIn)
      else $error("interrupt cleared away from stop");
   auto_restart_a: assert property (convDone && adcEnable |-> ##[1:4] integrating)
      else $error("integration not restarted");
endmodule

bind light_sensor_serial_register_port lsrp_properties #(
   .STEP_CYCLES(STEP_CYCLES)
) lsrp_properties_inst (
   .clk(clk),
   .rst_b(rst_b),
   .clkEn(clkEn),
   .sclIn(sclIn),
   .sdaIn(sdaIn),
   .sdaOe(sdaOe),
   .sdaOut(sdaOut),
   .addrSel(addrSel),
   .convDone(convDone),
   .convResult(convResult),
   .intEvent(intEvent),
   .powerOn(powerOn),
   .adcEnable(adcEnable),
   .integrating(integrating),
   .intOut(intOut)
);

// ==== sim/i2c_master_model.sv ====
`timescale 1ns/1ps
// --------------------------------------------------------------
// bus master: drives clock, pulls data low when sdaOe is high
// --------------------------------------------------------------
module i2c_master_model #(
   parameter int Q = 10
) (
   input  wire logic clk,
   input  wire logic sdaBus,
   output logic      scl,
   output logic      sdaOe,
   output logic      rxValid,
   output logic [7:0] rxVal
);
   // idle bus: clock stands high, data released
   initial begin
      scl = 1'b1;
      sdaOe = 1'b0;
      rxValid = 1'b0;
      rxVal = 8'h00;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // start or repeated start: data falls while clock high
   task automatic start();
      sdaOe = 1'b0;
      tick(Q);
      scl = 1'b1;
      tick(Q);
      sdaOe = 1'b1;
      tick(Q);
      scl = 1'b0;
      tick(Q);
   endtask

   // stop ends every transfer, block reads included
   task automatic stop();
      sdaOe = 1'b1;
      tick(Q);
      scl = 1'b1;
      tick(Q);
      sdaOe = 1'b0;
      tick(2 * Q);
   endtask

   // data set while clock low, sampled mid high phase
   task automatic bitIo(input logic b, output logic r);
      sdaOe = !b;
      tick(Q);
      scl = 1'b1;
      tick(Q);
      r = sdaBus;
      tick(Q);
      scl = 1'b0;
      tick(Q);
   endtask

   task automatic report(input logic [7:0] v);
      rxVal = v;
      rxValid = 1'b1;
      tick(1);
      rxValid = 1'b0;
   endtask

   // msb first, then ack bit reported as 0 ack / 1 nack
   task automatic sendByte(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitIo(d[i], r);
      bitIo(1'b1, r);
      report({7'h00, r});
   endtask

   // last byte of a read is refused with a nack
   task automatic readByte(input logic last);
      logic [7:0] v;
      logic       r;
      for (int i = 7; i >= 0; i--) begin
         bitIo(1'b1, r);
         v[i] = r;
      end
      bitIo(last, r);
      report(v);
   endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import lsrp_pkg::*;
   logic         clk;
   logic         rst_b;
   logic         clkEn;
   logic         convDone;
   logic         intEvent;
   addr_sel_t    addrSel;
   conv_result_t convResult;
   logic         sdaOe;
   logic         sdaOut;
   logic         powerOn;
   logic         adcEnable;
   logic         integrating;
   logic         intOut;
   logic         scl;
   logic         mSdaOe;
   logic         rxValid;
   logic [7:0]   rxVal;
   logic [31:0]  rng;
   logic [6:0]   devAddr;
   logic [7:0]   t;
   logic [7:0]   u;
   logic [7:0]   expQ[$];
   logic [6:0]   addrs[3];
   int           errors;
   int           checks;
   wire          sdaBus = !(mSdaOe || sdaOe); // pulled up when nobody drives

   light_sensor_serial_register_port #(.STEP_CYCLES(10)) light_sensor_serial_register_port_inst (
      .clk(clk), .rst_b(rst_b), .clkEn(clkEn), .sclIn(scl), .sdaIn(sdaBus),
      .sdaOe(sdaOe), .sdaOut(sdaOut), .addrSel(addrSel), .convDone(convDone),
      .convResult(convResult), .intEvent(intEvent), .powerOn(powerOn),
      .adcEnable(adcEnable), .integrating(integrating), .intOut(intOut));
   i2c_master_model #(.Q(10)) i2c_master_model_inst (
      .clk(clk), .sdaBus(sdaBus), .scl(scl), .sdaOe(mSdaOe),
      .rxValid(rxValid), .rxVal(rxVal));

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   always #5 clk = ~clk;

   task automatic finish_test();
      if (errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checks++;
      if (seen !== want) begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   function automatic logic [7:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng[7:0];
   endfunction

   // every reported byte is matched against the oldest note
   always @(posedge clk) begin
      if (rxValid === 1'b1) begin
         if (expQ.size() > 0) check(rxVal, expQ.pop_front());
         else errors++;
      end
   end

   task automatic wr(input logic [7:0] b);
      expQ.push_back(8'h00);
      i2c_master_model_inst.sendByte(b);
   endtask
   task automatic go(input logic rw);
      i2c_master_model_inst.start();
      wr({devAddr, rw});
   endtask
   task automatic rd(input logic [7:0] want, input logic last);
      expQ.push_back(want);
      i2c_master_model_inst.readByte(last);
   endtask
   // command byte, repeated start, read address
   task automatic point(input logic [7:0] cmd);
      go(1'b0);
      wr(cmd);
      go(1'b1);
   endtask
   task automatic fin();
      i2c_master_model_inst.stop();
   endtask
   task automatic waitFor(input logic which, input logic want);
      int n;
      n = 0;
      while (((which ? integrating : intOut) !== want) && n < 500) begin
         @(negedge clk);
         n++;
      end
      check({7'h00, (which ? integrating : intOut)}, {7'h00, want});
      if (n == 500) finish_test();
   endtask

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      clkEn = 1'b1;
      convDone = 1'b0;
      intEvent = 1'b0;
      convResult = '0;
      addrSel = SelGnd;
      rng = 32'd73;
      errors = 0;
      checks = 0;
      addrs = '{AddrGnd, AddrFloat, AddrVdd};
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      clkEn = 1'b0;
      repeat (6) @(negedge clk);
      clkEn = 1'b1;
      check({6'h00, adcEnable, powerOn}, 8'h00);
      // each select level answers its own address only
      for (int s = 0; s < 3; s++) begin
         addrSel = addr_sel_t'(s);
         devAddr = addrs[s];
         go(1'b0);
         fin();
         i2c_master_model_inst.start();
         expQ.push_back(8'h01);
         i2c_master_model_inst.sendByte({addrs[(s + 1) % 3], 1'b0});
         fin();
      end
      // control write then combined read back
      go(1'b0);
      wr(8'h80);
      wr(8'h03);
      fin();
      check({6'h00, adcEnable, powerOn}, 8'h03);
      point(8'h80);
      rd(8'h03, 1'b1);
      fin();
      // auto-increment through timing and interrupt control
      t = xs() | 8'h01;
      u = xs();
      go(1'b0);
      wr(8'ha1);
      wr(t);
      wr(u);
      fin();
      point(8'ha1);
      rd(t, 1'b0);
      rd(u, 1'b1);
      fin();
      // repeated byte, read without command, data-only write
      t = xs();
      go(1'b0);
      wr(8'h83);
      wr(t);
      fin();
      go(1'b1);
      rd(t, 1'b0);
      rd(t, 1'b1);
      fin();
      t = xs() & 8'h7f;
      go(1'b0);
      wr(t);
      fin();
      go(1'b1);
      rd(t, 1'b1);
      fin();
      // conversion result lands in both channel registers
      convResult = {xs(), xs(), xs(), xs()};
      convDone = 1'b1;
      @(negedge clk);
      convDone = 1'b0;
      waitFor(1'b1, 1'b1);
      point(8'hb4);
      rd(convResult.chan0[7:0], 1'b0);
      rd(convResult.chan0[15:8], 1'b0);
      rd(convResult.chan1[7:0], 1'b0);
      rd(convResult.chan1[15:8], 1'b1);
      fin();
      point(8'h80);
      rd(8'h13, 1'b1);
      fin();
      // unmapped place drops writes and reads zero
      go(1'b0);
      wr(8'h88);
      wr(8'h55);
      fin();
      point(8'h88);
      rd(8'h00, 1'b1);
      fin();
      // interrupt raised, then cleared by one send byte
      intEvent = 1'b1;
      @(negedge clk);
      intEvent = 1'b0;
      waitFor(1'b0, 1'b1);
      go(1'b0);
      wr(8'he1);
      fin();
      waitFor(1'b0, 1'b0);
      // manual integration start and stop
      go(1'b0);
      wr(8'h81);
      wr(8'h00);
      fin();
      waitFor(1'b1, 1'b0);
      go(1'b0);
      wr(8'he3);
      fin();
      waitFor(1'b1, 1'b1);
      repeat (100) @(negedge clk);
      go(1'b0);
      wr(8'he2);
      fin();
      waitFor(1'b1, 1'b0);
      point(8'h99);
      rd(8'h00, 1'b1);
      fin();
      repeat (20) @(negedge clk);
      if (expQ.size() != 0) errors++;
      finish_test();
   end
endmodule
